// ==== tpnd_top.v ====
// pattern output unit registers with next-data transfer on timer strobes
`timescale 1ns/1ns
`default_nettype none
`include "tpnd_regs.vh"

module tpnd_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [3:0]  compare_match,
  output reg  [15:0] pattern_out_pins,
  output reg  [15:0] pattern_out_oe
);

  // ************************************************************
  // storage
  // ************************************************************
  reg  [15:0] pin_function_upper;
  reg  [15:0] pin_function_lower;
  reg  [15:0] pattern_port_data;
  reg  [7:0]  next_data_low_pair;
  reg  [7:0]  next_data_high_pair;
  reg  [7:0]  output_enable_low_pair;
  reg  [7:0]  output_enable_high_pair;
  reg  [7:0]  trigger_select_reg;
  reg  [31:0] wr_addr;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_strb;

  // ************************************************************
  // helpers
  // ************************************************************
  function [31:0] byte_addr;
    input [27:0] idx;
    begin
      byte_addr = {2'b00, idx[27:0], 2'b00};
    end
  endfunction

  // read view of a next-data byte; upper byte holds the upper nibble
  function [7:0] nd_read;
    input       shared;
    input       is_alt;
    input [7:0] data;
    begin
      if (shared)
        nd_read = is_alt ? `TPND_RESERVED_BYTE : data;
      else if (is_alt)
        nd_read = {`TPND_RESERVED_NIBBLE, data[3:0]};
      else
        nd_read = {data[7:4], `TPND_RESERVED_NIBBLE};
    end
  endfunction

  // which next-data bits a write at this byte may change
  function [7:0] nd_mask;
    input shared;
    input is_alt;
    begin
      if (shared)
        nd_mask = is_alt ? 8'h00 : 8'hFF;
      else
        nd_mask = is_alt ? 8'h0F : 8'hF0;
    end
  endfunction

  // byte lane strobes widened to a 16-bit mask
  function [15:0] lane_mask;
    input [3:0] strb;
    begin
      lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // ************************************************************
  // trigger decode
  // ************************************************************
  wire [1:0] sel_g0 = trigger_select_reg[1:0];
  wire [1:0] sel_g1 = trigger_select_reg[3:2];
  wire [1:0] sel_g2 = trigger_select_reg[5:4];
  wire [1:0] sel_g3 = trigger_select_reg[7:6];
  // layout tracks the selectors combinationally, no extra latency
  wire       low_shared  = (sel_g1 == sel_g0);
  wire       high_shared = (sel_g3 == sel_g2);
  wire [3:0] grp_fire = {compare_match[sel_g3], compare_match[sel_g2],
                         compare_match[sel_g1], compare_match[sel_g0]};
  wire [15:0] fire_mask = {{4{grp_fire[3]}}, {4{grp_fire[2]}},
                           {4{grp_fire[1]}}, {4{grp_fire[0]}}};
  wire [15:0] oe_all = {output_enable_high_pair, output_enable_low_pair};
  wire [15:0] next_all = {next_data_high_pair, next_data_low_pair};
  wire [15:0] copy_mask = fire_mask & oe_all;

  // ************************************************************
  // write path
  // ************************************************************
  wire        wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire [15:0] wr_lane = lane_mask(wr_strb);
  wire        hit_ndhu = wr_addr == byte_addr(`TPND_IDX_ND_HIGH_UPPER);
  wire        hit_ndlu = wr_addr == byte_addr(`TPND_IDX_ND_LOW_UPPER);
  wire        hit_ndha = wr_addr == byte_addr(`TPND_IDX_ND_HIGH_ALT);
  wire        hit_ndla = wr_addr == byte_addr(`TPND_IDX_ND_LOW_ALT);
  wire        hit_pfu  = wr_addr == byte_addr(`TPND_IDX_PIN_FN_UPPER);
  wire        hit_pfl  = wr_addr == byte_addr(`TPND_IDX_PIN_FN_LOWER);
  wire        hit_pd   = wr_addr == byte_addr(`TPND_IDX_PORT_DATA);
  wire        hit_ts   = wr_addr == byte_addr(`TPND_IDX_TRIG_SEL);
  wire        hit_oeh  = wr_addr == byte_addr(`TPND_IDX_OE_HIGH);
  wire        hit_oel  = wr_addr == byte_addr(`TPND_IDX_OE_LOW);
  wire        wr_mapped = hit_ndhu | hit_ndlu | hit_ndha | hit_ndla |
                          hit_pfu | hit_pfl | hit_pd | hit_ts |
                          hit_oeh | hit_oel;
  // reserved bits are masked off here, so ones written there are dropped
  wire [7:0]  low_wmask  = !wr_strb[0] ? 8'h00 :
                           hit_ndlu ? nd_mask(low_shared, 1'b0) :
                           hit_ndla ? nd_mask(low_shared, 1'b1) : 8'h00;
  wire [7:0]  high_wmask = !wr_strb[0] ? 8'h00 :
                           hit_ndhu ? nd_mask(high_shared, 1'b0) :
                           hit_ndha ? nd_mask(high_shared, 1'b1) : 8'h00;
  wire [15:0] pd_wmask = (wr_go && hit_pd) ? (wr_lane & ~oe_all) : 16'h0000;

  reg  [15:0] next_port_data;
  always @* begin
    next_port_data = (pattern_port_data & ~pd_wmask) |
                     (wr_data[15:0] & pd_wmask);
    // strobe seen at this edge, new pins next cycle
    next_port_data = (next_port_data & ~copy_mask) |
                     (next_all & copy_mask);
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_function_upper      <= `TPND_RST_PIN_FN;
      pin_function_lower      <= `TPND_RST_PIN_FN;
      pattern_port_data       <= `TPND_RST_PORT_DATA;
      next_data_low_pair      <= `TPND_RST_ND;
      next_data_high_pair     <= `TPND_RST_ND;
      output_enable_low_pair  <= `TPND_RST_OE;
      output_enable_high_pair <= `TPND_RST_OE;
      trigger_select_reg      <= `TPND_RST_TRIG_SEL;
      pattern_out_pins        <= `TPND_RST_PORT_DATA;
      pattern_out_oe          <= 16'h0000;
    end else begin
      pattern_port_data <= next_port_data;
      pattern_out_pins  <= next_port_data;
      pattern_out_oe    <= {
        pin_function_upper[15:14] == `TPND_PIN_FN_PATTERN,
        pin_function_upper[13:12] == `TPND_PIN_FN_PATTERN,
        pin_function_upper[11:10] == `TPND_PIN_FN_PATTERN,
        pin_function_upper[9:8]   == `TPND_PIN_FN_PATTERN,
        pin_function_upper[7:6]   == `TPND_PIN_FN_PATTERN,
        pin_function_upper[5:4]   == `TPND_PIN_FN_PATTERN,
        pin_function_upper[3:2]   == `TPND_PIN_FN_PATTERN,
        pin_function_upper[1:0]   == `TPND_PIN_FN_PATTERN,
        pin_function_lower[15:14] == `TPND_PIN_FN_PATTERN,
        pin_function_lower[13:12] == `TPND_PIN_FN_PATTERN,
        pin_function_lower[11:10] == `TPND_PIN_FN_PATTERN,
        pin_function_lower[9:8]   == `TPND_PIN_FN_PATTERN,
        pin_function_lower[7:6]   == `TPND_PIN_FN_PATTERN,
        pin_function_lower[5:4]   == `TPND_PIN_FN_PATTERN,
        pin_function_lower[3:2]   == `TPND_PIN_FN_PATTERN,
        pin_function_lower[1:0]   == `TPND_PIN_FN_PATTERN};
      if (wr_go) begin
        if (hit_pfu)
          pin_function_upper <= (pin_function_upper & ~wr_lane) |
                                (wr_data[15:0] & wr_lane);
        if (hit_pfl)
          pin_function_lower <= (pin_function_lower & ~wr_lane) |
                                (wr_data[15:0] & wr_lane);
        next_data_low_pair  <= (next_data_low_pair & ~low_wmask) |
                               (wr_data[7:0] & low_wmask);
        next_data_high_pair <= (next_data_high_pair & ~high_wmask) |
                               (wr_data[7:0] & high_wmask);
        if (hit_ts && wr_strb[0])
          trigger_select_reg <= wr_data[7:0];
        if (hit_oeh && wr_strb[0])
          output_enable_high_pair <= wr_data[7:0];
        if (hit_oel && wr_strb[0])
          output_enable_low_pair <= wr_data[7:0];
      end
    end
  end

  // ************************************************************
  // bus handshakes
  // ************************************************************
  // one write and one read in flight; ready drops once a beat is held
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TPND_RESP_OKAY;
      wr_addr       <= 32'h00000000;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr       <= {s_axi_awaddr[31:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `TPND_RESP_OKAY : `TPND_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  wire [31:0] rd_addr = {s_axi_araddr[31:2], 2'b00};
  reg  [15:0] rd_val;
  reg         rd_ok;
  always @* begin
    rd_ok  = 1'b1;
    rd_val = 16'h0000;
    if (rd_addr == byte_addr(`TPND_IDX_ND_HIGH_UPPER))
      rd_val = {8'h00, nd_read(high_shared, 1'b0, next_data_high_pair)};
    else if (rd_addr == byte_addr(`TPND_IDX_ND_LOW_UPPER))
      rd_val = {8'h00, nd_read(low_shared, 1'b0, next_data_low_pair)};
    else if (rd_addr == byte_addr(`TPND_IDX_ND_HIGH_ALT))
      rd_val = {8'h00, nd_read(high_shared, 1'b1, next_data_high_pair)};
    else if (rd_addr == byte_addr(`TPND_IDX_ND_LOW_ALT))
      rd_val = {8'h00, nd_read(low_shared, 1'b1, next_data_low_pair)};
    else if (rd_addr == byte_addr(`TPND_IDX_PIN_FN_UPPER))
      rd_val = pin_function_upper;
    else if (rd_addr == byte_addr(`TPND_IDX_PIN_FN_LOWER))
      rd_val = pin_function_lower;
    else if (rd_addr == byte_addr(`TPND_IDX_PORT_DATA))
      rd_val = pattern_port_data;
    else if (rd_addr == byte_addr(`TPND_IDX_TRIG_SEL))
      rd_val = {8'h00, trigger_select_reg};
    else if (rd_addr == byte_addr(`TPND_IDX_OE_HIGH))
      rd_val = {8'h00, output_enable_high_pair};
    else if (rd_addr == byte_addr(`TPND_IDX_OE_LOW))
      rd_val = {8'h00, output_enable_low_pair};
    else
      rd_ok = 1'b0;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `TPND_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_val};
        s_axi_rresp   <= rd_ok ? `TPND_RESP_OKAY : `TPND_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // tpnd_top
`default_nettype wire

// ==== tpnd_regs.vh ====
// register map, field positions and reset values of the pattern output unit
//
// What this block does
// - two 16-bit pin function registers, two bits/pin
// - 16-bit port data register drives pins
// - enabled port data bits ignore software writes
// - low pair next data copies to bits 7..0
// - high pair next data copies to bits 15..8
// - low pair next data resets to zero
// - high pair next data resets to zero
// - shared low trigger: one byte holds both nibbles
// - shared low trigger: alternate byte reads ones
// - split low trigger: nibbles at separate bytes
// - shared high trigger: one byte, alternate reads ones
// - split high trigger: nibbles at separate bytes
// - only enabled bits take next data
// - 2-bit trigger selectors per group, reset 11
`ifndef TPND_REGS_VH
`define TPND_REGS_VH

// ************************************************************
// register indices, byte address is four times the index
// ************************************************************
`define TPND_IDX_ND_HIGH_UPPER 28'h5FFFFF4
`define TPND_IDX_ND_LOW_UPPER  28'h5FFFFF5
`define TPND_IDX_ND_HIGH_ALT   28'h5FFFFF6
`define TPND_IDX_ND_LOW_ALT    28'h5FFFFF7
`define TPND_IDX_PIN_FN_UPPER  28'h5FFFFCC
`define TPND_IDX_PIN_FN_LOWER  28'h5FFFFCE
`define TPND_IDX_PORT_DATA     28'h5FFFFC2
`define TPND_IDX_TRIG_SEL      28'h5FFFFF1
`define TPND_IDX_OE_HIGH       28'h5FFFFF2
`define TPND_IDX_OE_LOW        28'h5FFFFF3

// ************************************************************
// reset values and fields
// ************************************************************
`define TPND_RST_ND            8'h00
`define TPND_RST_TRIG_SEL      8'hFF
`define TPND_RST_OE            8'h00
`define TPND_RST_PIN_FN        16'h0000
`define TPND_RST_PORT_DATA     16'h0000
`define TPND_RESERVED_NIBBLE   4'hF
`define TPND_RESERVED_BYTE     8'hFF
`define TPND_PIN_FN_PATTERN    2'h3
`define TPND_RESP_OKAY         2'h0
`define TPND_RESP_SLVERR       2'h2

`endif

// ==== tpnd_chk.sv ====
// port checker of the pattern output unit
`timescale 1ns/1ns
`default_nettype none
module tpnd_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  compare_match,
  input wire logic [15:0] pattern_out_pins,
  input wire logic [15:0] pattern_out_oe
);
  // ****
  // assertions
  // ****
  wire cm_any = |compare_match;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_resp;
    ##2 s_axi_bvalid;
  endsequence
  wr_answer_a: assert property (wr_take |-> wr_resp)
    else $error("write response not on time");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken while busy");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  // pins move one edge after a strobe or as the write answer rises
  pin_cause_a: assert property (
    $changed(pattern_out_pins) |-> $past(cm_any) || $rose(s_axi_bvalid))
    else $error("pins changed without cause");
  oe_cause_a: assert property (
    $changed(pattern_out_oe) |-> $past(s_axi_bvalid) ||
    $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("drive enable changed without write");
endmodule // tpnd_chk
`default_nettype wire

// ==== tpnd_timer.sv ====
// timer model giving one-cycle compare-match strobes
`timescale 1ns/1ns
`default_nettype none
module tpnd_timer (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] fire,
  output var  logic [3:0] compare_match
);
  // registered so strobes leave just after an edge, as a real timer does
  always @(posedge aclk) begin
    if (!aresetn) begin
      compare_match <= 4'h0;
    end else begin
      compare_match <= fire;
    end
  end
endmodule // tpnd_timer
`default_nettype wire

// ==== timed_pattern_next_data_regs_tb.sv ====
// testbench of the pattern output unit registers
`timescale 1ns/1ns
`default_nettype none
module timed_pattern_next_data_regs_tb;
  localparam logic [31:0] NHU = 32'h17FFFFD0, NLU = 32'h17FFFFD4;
  localparam logic [31:0] NHA = 32'h17FFFFD8, NLA = 32'h17FFFFDC;
  localparam logic [31:0] PD = 32'h17FFFF08, PFU = 32'h17FFFF30;
  localparam logic [31:0] PFL = 32'h17FFFF38, TS = 32'h17FFFFC4;
  localparam logic [31:0] OEH = 32'h17FFFFC8, OEL = 32'h17FFFFCC;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  fire, cm, wstrb;
  logic [15:0] pins, oe;
  int          errors, n_compared, cyc;
  tpnd_top i_tpnd_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .compare_match(cm),
    .pattern_out_pins(pins), .pattern_out_oe(oe));
  tpnd_timer i_tpnd_timer (.aclk(aclk), .aresetn(aresetn), .fire(fire),
    .compare_match(cm));
  always #4 aclk = ~aclk;
  // ****
  // tasks
  // ****
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      finish_test;
    end
  end
  task chk(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  // ready offered with the request; one idle edge keeps calls apart
  task wr(input logic [31:0] a, d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task rd(input logic [31:0] a, e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready === 1'h1)
        arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    chk($sformatf("rdata %h", a), e, rdata);
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  // copy lands two edges after fire, pins at the same edge
  task strobe(input logic [3:0] ch);
    fire <= ch;
    @(posedge aclk);
    fire <= 4'h0;
    repeat (4) @(posedge aclk);
  endtask
  // ****
  // tests
  // ****
  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, wdata, araddr} = 96'h0;
    fire = 4'h0;
    wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(NLU, 32'h00, 2'h0);
    rd(NHU, 32'h00, 2'h0);
    rd(NLA, 32'hFF, 2'h0);
    rd(NHA, 32'hFF, 2'h0);
    rd(TS, 32'hFF, 2'h0);
    rd(PFU, 32'h0000, 2'h0);
    rd(32'h10, 32'h0, 2'h2);
    wr(32'h10, 32'h1, 2'h2);
    $display("reset and map test done");
    wr(NLU, 32'hA5, 2'h0);
    rd(NLU, 32'hA5, 2'h0);
    wr(NLA, 32'h00, 2'h0);
    rd(NLA, 32'hFF, 2'h0);
    wr(NHU, 32'h3C, 2'h0);
    rd(NHU, 32'h3C, 2'h0);
    wr(PFU, 32'hFFFF, 2'h0);
    wr(PFL, 32'hFFFF, 2'h0);
    rd(PFL, 32'hFFFF, 2'h0);
    chk("oe", 32'hFFFF, {16'h0, oe});
    wr(PD, 32'h1234, 2'h0);
    rd(PD, 32'h1234, 2'h0);
    chk("pins", 32'h1234, {16'h0, pins});
    wr(OEL, 32'h0F, 2'h0);
    wr(OEH, 32'hF0, 2'h0);
    wr(PD, 32'h0000, 2'h0);
    rd(PD, 32'h1004, 2'h0);
    strobe(4'h1);
    rd(PD, 32'h1004, 2'h0);
    strobe(4'h8);
    rd(PD, 32'h3005, 2'h0);
    chk("pins", 32'h3005, {16'h0, pins});
    $display("shared trigger test done");
    wr(TS, 32'hE4, 2'h0);
    rd(NLU, 32'hAF, 2'h0);
    rd(NLA, 32'hF5, 2'h0);
    rd(NHU, 32'h3F, 2'h0);
    rd(NHA, 32'hFC, 2'h0);
    wr(NLA, 32'hF9, 2'h0);
    wr(NHU, 32'h7F, 2'h0);
    strobe(4'h1);
    rd(PD, 32'h3009, 2'h0);
    strobe(4'h8);
    rd(PD, 32'h7009, 2'h0);
    wr(TS, 32'hFF, 2'h0);
    rd(NLA, 32'hFF, 2'h0);
    rd(NLU, 32'hA9, 2'h0);
    rd(NHU, 32'h7C, 2'h0);
    wstrb <= 4'h1;
    wr(PD, 32'h0FF0, 2'h0);
    wstrb <= 4'hF;
    rd(PD, 32'h70F9, 2'h0);
    chk("pins", 32'h70F9, {16'h0, pins});
    $display("split trigger test done");
    finish_test;
  end
endmodule // timed_pattern_next_data_regs_tb
bind tpnd_top tpnd_chk i_tpnd_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .compare_match(compare_match),
  .pattern_out_pins(pattern_out_pins), .pattern_out_oe(pattern_out_oe));
`default_nettype wire
